// file: core/grab_pkg.sv
// Constants for the capture-position, snapshot and line-control bank
// Notes on behaviour
// - Field capture index sits in bits 6-4.
// - Line capture index msb sits in bit 3.
// - Pixel capture index top bits sit 2-0.
// - Snapshot registers 34-3C ignore host writes.
// - Green/luma low bits in 37 bits 5-4.
// - Blue/U low bits in 37 bits 3-2.
// - Red/V low bits in 37 bits 1-0.
// - Processed luma low bits in 3C bits 7-6.
// - Mixed sync low bits in 3C bits 5-4.
// - U difference low bits in 3C bits 3-2.
// - V difference low bits in 3C bits 1-0.
// - Sequential address increment stops at 3F.
// - Extension high: NTSC V flag through line 20.
// - Extension low: NTSC V flag to line 16.
// - Extension bit ignored when decoding PAL.
// - Bypass high: no pedestal removal, LINE_IDENTIFIER 0-6.
// - Bits 5-3 pass field-0 caption lines flat.
// - Bits 2-0 pass field-1 caption lines flat.
// - Phase register returns top eight sine bits.
// - Enabled: capture once per line at index.
// - Line flag set on capture; host clears it.
package grab_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CAPTURE_CONTROL  = 8'h30;
  localparam logic [7:0] ADDR_PIXEL_INDEX_LOW  = 8'h31;
  localparam logic [7:0] ADDR_LINE_INDEX_LOW   = 8'h32;
  localparam logic [7:0] ADDR_CAPTURE_POS_HIGH = 8'h33;
  localparam logic [7:0] ADDR_GREEN_HIGH       = 8'h34;
  localparam logic [7:0] ADDR_BLUE_HIGH        = 8'h35;
  localparam logic [7:0] ADDR_RED_HIGH         = 8'h36;
  localparam logic [7:0] ADDR_COLOUR_LOW       = 8'h37;
  localparam logic [7:0] ADDR_LUMA_HIGH        = 8'h38;
  localparam logic [7:0] ADDR_SYNC_HIGH        = 8'h39;
  localparam logic [7:0] ADDR_CB_HIGH          = 8'h3a;
  localparam logic [7:0] ADDR_CR_HIGH          = 8'h3b;
  localparam logic [7:0] ADDR_COMPONENT_LOW    = 8'h3c;
  localparam logic [7:0] ADDR_TEST_FIRST       = 8'h3d;
  localparam logic [7:0] ADDR_TEST_SECOND      = 8'h3e;
  localparam logic [7:0] ADDR_VBI_CONTROL      = 8'h3f;
  localparam logic [7:0] ADDR_PHASE_READBACK   = 8'h40;
  localparam logic [7:0] ADDR_INCREMENT_LIMIT  = 8'h3f;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam int CTRL_LINE_FLAG_BIT     = 6;
  localparam int CTRL_LINE_ENABLE_BIT   = 5;
  localparam int CTRL_PIXEL_ENABLE_BIT  = 1;
  localparam int POS_FIELD_HI           = 6;
  localparam int POS_FIELD_LO           = 4;
  localparam int POS_LINE_MSB           = 3;
  localparam int POS_PIXEL_HI           = 2;
  localparam int VBI_EXTEND_BIT         = 7;
  localparam int VBI_SETUP_BYPASS_BIT   = 6;
  localparam int CAPTION_BITS           = 6;

  // ****************************************
  // Snapshot channels
  // ****************************************
  localparam int SAMPLE_W  = 10;
  localparam int NUM_CH    = 7;
  localparam int CH_GREEN  = 0;
  localparam int CH_BLUE   = 1;
  localparam int CH_RED    = 2;
  localparam int CH_LUMA   = 3;
  localparam int CH_SYNC   = 4;
  localparam int CH_CB     = 5;
  localparam int CH_CR     = 6;

  // ****************************************
  // Vertical interval line numbers
  // ****************************************
  localparam logic [9:0] NTSC_V_LAST_NORMAL = 10'd16;
  localparam logic [9:0] NTSC_V_LAST_EXT    = 10'd20;
  localparam logic [4:0] SETUP_LID_LAST     = 5'h06;
  // Element b serves caption bit b
  localparam logic [9:0] NTSC_CAPTION_LINE [CAPTION_BITS] =
    '{10'd285, 10'd284, 10'd283, 10'd23, 10'd22, 10'd21};
  localparam logic [9:0] PAL_CAPTION_LINE [CAPTION_BITS] =
    '{10'd336, 10'd335, 10'd334, 10'd24, 10'd23, 10'd22};

endpackage

// file: core/snapshot_if.sv
// Sample bus between the register bank and the snapshot store
`timescale 1ns/1ps
interface snapshot_if;
  logic [grab_pkg::SAMPLE_W-1:0] sample [grab_pkg::NUM_CH];
  logic [grab_pkg::SAMPLE_W-1:0] held   [grab_pkg::NUM_CH];
  logic                          capture;
  modport feed  (output sample, output capture, input held);
  modport store (input sample, input capture, output held);
endinterface

// file: core/snapshot_store.sv
// Holds one captured sample per channel
`timescale 1ns/1ps
module snapshot_store
(
  input  wire logic   clock_in,
  input  wire logic   sys_rst_in,
  snapshot_if.store   snap
);

  // ****************************************
  // One shared strobe for every channel
  // ****************************************
  // A single enable keeps high and low parts of a read coherent
  for (genvar ch = 0; ch < grab_pkg::NUM_CH; ch++)
  begin : g_ch
    logic [grab_pkg::SAMPLE_W-1:0] held_q;
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
      if (sys_rst_in)
        held_q <= '0;
      else if (snap.capture)
        held_q <= snap.sample[ch];
    end
    assign snap.held[ch] = held_q;
  end

endmodule

// file: core/vbi_line_control.sv
// Timing reference V flag, pedestal bypass and caption passthrough
`timescale 1ns/1ps
module vbi_line_control
(
  input  wire logic                           clock_in,
  input  wire logic                           sys_rst_in,
  input  wire logic [7:0]                     vbi_control_in,
  input  wire logic                           pal_mode_in,
  input  wire logic                           vblank_in,
  input  wire logic [9:0]                     line_in_field_in,
  input  wire logic [9:0]                     frame_line_in,
  input  wire logic [4:0]                     line_identifier_in,
  output logic                                trs_v_flag_out,
  output logic                                setup_strip_bypass_out,
  output logic                                caption_flat_out
);

  // ****************************************
  // Line decode
  // ****************************************
  wire       extend   = vbi_control_in[grab_pkg::VBI_EXTEND_BIT];
  wire [9:0] v_last   = extend ? grab_pkg::NTSC_V_LAST_EXT
                               : grab_pkg::NTSC_V_LAST_NORMAL;
  wire       ntsc_v   = (line_in_field_in <= v_last);
  // PAL keeps the timing generator's own flag
  wire       v_next   = pal_mode_in ? vblank_in : ntsc_v;
  wire       setup_lid = vbi_control_in[grab_pkg::VBI_SETUP_BYPASS_BIT]
                      & (line_identifier_in <= grab_pkg::SETUP_LID_LAST);

  logic [grab_pkg::CAPTION_BITS-1:0] hit;
  for (genvar b = 0; b < grab_pkg::CAPTION_BITS; b++)
  begin : g_cap
    wire [9:0] target = pal_mode_in ? grab_pkg::PAL_CAPTION_LINE[b]
                                    : grab_pkg::NTSC_CAPTION_LINE[b];
    assign hit[b] = vbi_control_in[b]
                  & (frame_line_in == target);
  end
  wire flat_next = |hit;

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      trs_v_flag_out         <= 1'b0;
      setup_strip_bypass_out <= 1'b0;
      caption_flat_out       <= 1'b0;
    end
    else
    begin
      trs_v_flag_out         <= v_next;
      // Flat caption lines also skip pedestal removal
      setup_strip_bypass_out <= setup_lid | flat_next;
      caption_flat_out       <= flat_next;
    end
  end

endmodule

// file: core/video_grab_regs.sv
// Capture position, sample snapshot and line control register bank
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module video_grab_regs
(
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic        reg_seq_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic [10:0] pixel_count_in,
  input  wire logic [8:0]  line_count_in,
  input  wire logic [2:0]  field_count_in,
  input  wire logic [9:0]  green_luma_capture_in,
  input  wire logic [9:0]  blue_diff_capture_in,
  input  wire logic [9:0]  red_diff_capture_in,
  input  wire logic [9:0]  luma_processor_stage_in,
  input  wire logic [9:0]  mixed_sync_in,
  input  wire logic [9:0]  cb_diff_in,
  input  wire logic [9:0]  cr_diff_in,
  input  wire logic [9:0]  oscillator_sine_in,
  input  wire logic        pal_mode_in,
  input  wire logic        vblank_in,
  input  wire logic [9:0]  line_in_field_in,
  input  wire logic [9:0]  frame_line_in,
  input  wire logic [4:0]  line_identifier_in,
  output logic             line_freeze_out,
  output logic             trs_v_flag_out,
  output logic             setup_strip_bypass_out,
  output logic             caption_flat_out
);

  // ****************************************
  // Address selection and auto increment
  // ****************************************
  logic [7:0] next_addr_q;
  wire  [7:0] acc_addr = reg_seq_in ? next_addr_q : reg_addr_in;
  wire        access   = reg_wr_in | reg_rd_in;
  // Pointer parks on the last control register
  wire  [7:0] inc_addr = (acc_addr >= grab_pkg::ADDR_INCREMENT_LIMIT)
                       ? acc_addr : acc_addr + 8'h01;

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      next_addr_q <= grab_pkg::REG_RESET;
    else if (access)
      next_addr_q <= inc_addr;
  end

  wire  [8:0] wr_sel   = {reg_wr_in, acc_addr};
  function automatic logic hits(input logic [8:0] a,
                                input logic [7:0] target);
    hits = (a == {1'b1, target});
  endfunction

  // ****************************************
  // Writable registers
  // ****************************************
  logic [7:0] capture_control_q;
  logic [7:0] pixel_index_low_q;
  logic [7:0] line_index_low_q;
  logic [7:0] capture_position_high_q;
  logic [7:0] test_control_first_q;
  logic [7:0] test_control_second_q;
  logic [7:0] vbi_line_control_q;

  wire wr_ctrl  = hits(wr_sel, grab_pkg::ADDR_CAPTURE_CONTROL);
  wire wr_plow  = hits(wr_sel, grab_pkg::ADDR_PIXEL_INDEX_LOW);
  wire wr_llow  = hits(wr_sel, grab_pkg::ADDR_LINE_INDEX_LOW);
  wire wr_pos   = hits(wr_sel, grab_pkg::ADDR_CAPTURE_POS_HIGH);
  wire wr_test1 = hits(wr_sel, grab_pkg::ADDR_TEST_FIRST);
  wire wr_test2 = hits(wr_sel, grab_pkg::ADDR_TEST_SECOND);
  wire wr_vbi   = hits(wr_sel, grab_pkg::ADDR_VBI_CONTROL);
  // No write decode for 34-3C or 40

  // ****************************************
  // Capture index fields
  // ****************************************
  wire [2:0]  field_capture_index =
    capture_position_high_q[grab_pkg::POS_FIELD_HI:grab_pkg::POS_FIELD_LO];
  wire [8:0]  line_capture_index  =
    {capture_position_high_q[grab_pkg::POS_LINE_MSB],
     line_index_low_q};
  wire [10:0] pixel_capture_index =
    {capture_position_high_q[grab_pkg::POS_PIXEL_HI:0],
     pixel_index_low_q};

  wire pixel_capture_enable =
    capture_control_q[grab_pkg::CTRL_PIXEL_ENABLE_BIT];
  wire line_capture_enable  =
    capture_control_q[grab_pkg::CTRL_LINE_ENABLE_BIT];
  wire line_capture_flag    =
    capture_control_q[grab_pkg::CTRL_LINE_FLAG_BIT];

  // ****************************************
  // Capture events
  // ****************************************
  // Pixel match fires once per line; disabled means samples hold
  wire pixel_hit   = pixel_capture_enable
                   & (pixel_count_in == pixel_capture_index);
  // A new line is taken only while the flag is clear
  wire line_hit    = line_capture_enable & ~line_capture_flag
                   & (pixel_count_in == 11'h000)
                   & (line_count_in == line_capture_index)
                   & (field_count_in == field_capture_index);

  // Hardware set wins over a host clear in the same cycle
  wire       flag_next = line_hit
                       | (wr_ctrl
                          ? reg_wdata_in[grab_pkg::CTRL_LINE_FLAG_BIT]
                            & line_capture_flag
                          : line_capture_flag);
  wire [7:0] ctrl_next = wr_ctrl ? reg_wdata_in : capture_control_q;

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      capture_control_q       <= grab_pkg::REG_RESET;
      pixel_index_low_q       <= grab_pkg::REG_RESET;
      line_index_low_q        <= grab_pkg::REG_RESET;
      capture_position_high_q <= grab_pkg::REG_RESET;
      test_control_first_q    <= grab_pkg::REG_RESET;
      test_control_second_q   <= grab_pkg::REG_RESET;
      vbi_line_control_q      <= grab_pkg::REG_RESET;
      line_freeze_out         <= 1'b0;
    end
    else
    begin
      capture_control_q <= {ctrl_next[7],
                            flag_next,
                            ctrl_next[5:0]};
      if (wr_plow)
        pixel_index_low_q <= reg_wdata_in;
      if (wr_llow)
        line_index_low_q <= reg_wdata_in;
      if (wr_pos)
        capture_position_high_q <= {1'b0, reg_wdata_in[6:0]};
      // Stored only; the host is expected to keep these at zero
      if (wr_test1)
        test_control_first_q <= reg_wdata_in;
      if (wr_test2)
        test_control_second_q <= reg_wdata_in;
      if (wr_vbi)
        vbi_line_control_q <= reg_wdata_in;
      line_freeze_out <= line_hit;
    end
  end

  // ****************************************
  // Snapshot store
  // ****************************************
  snapshot_if snap ();

  assign snap.capture                 = pixel_hit;
  assign snap.sample[grab_pkg::CH_GREEN] = green_luma_capture_in;
  assign snap.sample[grab_pkg::CH_BLUE]  = blue_diff_capture_in;
  assign snap.sample[grab_pkg::CH_RED]   = red_diff_capture_in;
  assign snap.sample[grab_pkg::CH_LUMA]  = luma_processor_stage_in;
  assign snap.sample[grab_pkg::CH_SYNC]  = mixed_sync_in;
  assign snap.sample[grab_pkg::CH_CB]    = cb_diff_in;
  assign snap.sample[grab_pkg::CH_CR]    = cr_diff_in;

  snapshot_store u_store
  (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .snap       (snap.store)
  );

  wire [9:0] g_s = snap.held[grab_pkg::CH_GREEN];
  wire [9:0] b_s = snap.held[grab_pkg::CH_BLUE];
  wire [9:0] r_s = snap.held[grab_pkg::CH_RED];
  wire [9:0] y_s = snap.held[grab_pkg::CH_LUMA];
  wire [9:0] m_s = snap.held[grab_pkg::CH_SYNC];
  wire [9:0] u_s = snap.held[grab_pkg::CH_CB];
  wire [9:0] v_s = snap.held[grab_pkg::CH_CR];

  // Reserved top pair of the colour low register reads zero
  wire [7:0] colour_low    = {2'b00,
                              g_s[1:0],
                              b_s[1:0],
                              r_s[1:0]};
  wire [7:0] component_low = {y_s[1:0],
                              m_s[1:0],
                              u_s[1:0],
                              v_s[1:0]};

  // ****************************************
  // Vertical interval control
  // ****************************************
  vbi_line_control u_vbi
  (
    .clock_in               (clock_in),
    .sys_rst_in             (sys_rst_in),
    .vbi_control_in         (vbi_line_control_q),
    .pal_mode_in            (pal_mode_in),
    .vblank_in              (vblank_in),
    .line_in_field_in       (line_in_field_in),
    .frame_line_in          (frame_line_in),
    .line_identifier_in     (line_identifier_in),
    .trs_v_flag_out         (trs_v_flag_out),
    .setup_strip_bypass_out (setup_strip_bypass_out),
    .caption_flat_out       (caption_flat_out)
  );

  // ****************************************
  // Read selection
  // ****************************************
  logic [7:0] rd_value;
  always_comb
  begin
    unique case (acc_addr)
      grab_pkg::ADDR_CAPTURE_CONTROL:  rd_value = capture_control_q;
      grab_pkg::ADDR_PIXEL_INDEX_LOW:  rd_value = pixel_index_low_q;
      grab_pkg::ADDR_LINE_INDEX_LOW:   rd_value = line_index_low_q;
      grab_pkg::ADDR_CAPTURE_POS_HIGH: rd_value = capture_position_high_q;
      grab_pkg::ADDR_GREEN_HIGH:       rd_value = g_s[9:2];
      grab_pkg::ADDR_BLUE_HIGH:        rd_value = b_s[9:2];
      grab_pkg::ADDR_RED_HIGH:         rd_value = r_s[9:2];
      grab_pkg::ADDR_COLOUR_LOW:       rd_value = colour_low;
      grab_pkg::ADDR_LUMA_HIGH:        rd_value = y_s[9:2];
      grab_pkg::ADDR_SYNC_HIGH:        rd_value = m_s[9:2];
      grab_pkg::ADDR_CB_HIGH:          rd_value = u_s[9:2];
      grab_pkg::ADDR_CR_HIGH:          rd_value = v_s[9:2];
      grab_pkg::ADDR_COMPONENT_LOW:    rd_value = component_low;
      grab_pkg::ADDR_TEST_FIRST:       rd_value = test_control_first_q;
      grab_pkg::ADDR_TEST_SECOND:      rd_value = test_control_second_q;
      grab_pkg::ADDR_VBI_CONTROL:      rd_value = vbi_line_control_q;
      // Live phase, sampled on the read strobe
      grab_pkg::ADDR_PHASE_READBACK:   rd_value = oscillator_sine_in[9:2];
      default:                         rd_value = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 8'h00;
    else
      reg_rdata_out <= reg_rd_in ? rd_value : 8'h00;
  end

endmodule

// file: tb/grab_checker_sva.sv
// Port checks for the capture position and line control bank
`timescale 1ns/1ps
module grab_checker
(
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic        reg_seq_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic [10:0] pixel_count_in,
  input wire logic [8:0]  line_count_in,
  input wire logic [2:0]  field_count_in,
  input wire logic [9:0]  oscillator_sine_in,
  input wire logic        pal_mode_in,
  input wire logic        vblank_in,
  input wire logic [9:0]  line_in_field_in,
  input wire logic [9:0]  frame_line_in,
  input wire logic [4:0]  line_identifier_in,
  input wire logic        line_freeze_out,
  input wire logic        trs_v_flag_out,
  input wire logic        setup_strip_bypass_out,
  input wire logic        caption_flat_out
);
  // ****************************************
  // Shadow of host controls
  // ****************************************
  // Direct writes only; pointer writes are not mirrored
  logic [7:0] ptr_q, ctrl_q, lo_q, pos_q, vbi_q;
  wire  [7:0] acc   = reg_seq_in ? ptr_q : reg_addr_in;
  wire  [7:0] ptr_d = (acc >= 8'h3f) ? acc : acc + 8'h01;
  wire        wr_dir = reg_wr_in && !reg_seq_in;
  wire  [9:0] f0 = pal_mode_in ? 10'h016 : 10'h015;
  wire  [9:0] f1 = pal_mode_in ? 10'h14e : 10'h11b;
  wire  [5:0] hit = vbi_q[5:0] & {frame_line_in == f0,
    frame_line_in == f0 + 10'h001, frame_line_in == f0 + 10'h002,
    frame_line_in == f1, frame_line_in == f1 + 10'h001,
    frame_line_in == f1 + 10'h002};
  wire        cap_any = |hit;
  wire        bypass  = (vbi_q[6] && line_identifier_in <= 5'h06) || cap_any;
  wire        grab_cond = ctrl_q[5] && pixel_count_in == 11'h000
    && line_count_in == {pos_q[3], lo_q} && field_count_in == pos_q[6:4];

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ptr_q  <= 8'h00;
      ctrl_q <= 8'h00;
      lo_q   <= 8'h00;
      pos_q  <= 8'h00;
      vbi_q  <= 8'h00;
    end
    else
    begin
      if (reg_wr_in || reg_rd_in)
        ptr_q <= ptr_d;
      if (wr_dir && reg_addr_in == 8'h30)
        ctrl_q <= reg_wdata_in;
      if (wr_dir && reg_addr_in == 8'h32)
        lo_q <= reg_wdata_in;
      if (wr_dir && reg_addr_in == 8'h33)
        pos_q <= reg_wdata_in;
      if (wr_dir && reg_addr_in == 8'h3f)
        vbi_q <= reg_wdata_in;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_phase_read;
    reg_rd_in && !reg_seq_in && reg_addr_in == 8'h40;
  endsequence
  sequence s_quiet;
    !line_freeze_out [*2];
  endsequence

  a_phase_read:
    assert property (s_phase_read
      |=> reg_rdata_out == $past(oscillator_sine_in[9:2]))
    else $error("phase read wrong");
  a_pos_read:
    assert property (reg_rd_in && !reg_seq_in && reg_addr_in == 8'h33
      |=> reg_rdata_out == {1'b0, pos_q[6:0]})
    else $error("position read wrong");
  a_seq_stop:
    assert property (reg_rd_in && reg_seq_in && ptr_q == 8'h3f
      |=> reg_rdata_out == vbi_q)
    else $error("pointer moved past 3f");
  a_ntsc_vflag:
    assert property (!pal_mode_in |=> trs_v_flag_out ==
      ($past(line_in_field_in) <= ($past(vbi_q[7]) ? 10'h014 : 10'h010)))
    else $error("ntsc v flag wrong");
  a_pal_vflag:
    assert property (pal_mode_in |=> trs_v_flag_out == $past(vblank_in))
    else $error("pal v flag wrong");
  a_setup_bypass:
    assert property (1'b1 |=> setup_strip_bypass_out == $past(bypass))
    else $error("pedestal bypass wrong");
  a_caption_flat:
    assert property (1'b1 |=> caption_flat_out == $past(cap_any))
    else $error("caption flat wrong");
  a_freeze_cause:
    assert property (line_freeze_out |->
      $past(grab_cond) || $past(grab_cond, 2))
    else $error("freeze without match");
  a_freeze_single:
    assert property (line_freeze_out |=> s_quiet)
    else $error("freeze repeated");
endmodule

bind video_grab_regs grab_checker grab_checker_inst (.*);

// file: tb/host_port_model.sv
// Host processor model on the register port
`timescale 1ns/1ps
module host_port_model
(
  input  wire logic       clock_in,
  output logic      [7:0] host_addr_out,
  output logic      [7:0] host_wdata_out,
  output logic            host_wr_out,
  output logic            host_rd_out,
  output logic            host_seq_out
);
  initial
  begin
    {host_addr_out, host_wdata_out} = '0;
    {host_wr_out, host_rd_out, host_seq_out} = '0;
  end

  // Test controls only ever get zero
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    host_addr_out  <= a;
    host_wdata_out <= (a == 8'h3d || a == 8'h3e) ? 8'h00 : d;
    host_seq_out   <= 1'b0;
    host_wr_out    <= 1'b1;
    @(posedge clock_in);
    host_wr_out    <= 1'b0;
  endtask

  task automatic get(input logic [7:0] a, input logic sq);
    @(posedge clock_in);
    host_addr_out <= a;
    host_seq_out  <= sq;
    host_rd_out   <= 1'b1;
    @(posedge clock_in);
    host_rd_out   <= 1'b0;
  endtask
endmodule

// file: tb/video_grab_and_vbi_line_controls_tb_top.sv
// Self-checking bench for the capture and line control bank
`timescale 1ns/1ps
module video_grab_and_vbi_line_controls_tb_top;
  logic        clock_in, sys_rst_in, pal_mode_in, vblank_in;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic        reg_wr_in, reg_rd_in, reg_seq_in;
  logic [10:0] pixel_count_in;
  logic [8:0]  line_count_in;
  logic [2:0]  field_count_in;
  logic [9:0]  oscillator_sine_in, line_in_field_in, frame_line_in;
  logic [4:0]  line_identifier_in;
  logic        line_freeze_out, trs_v_flag_out;
  logic        setup_strip_bypass_out, caption_flat_out;
  logic [9:0]  s [7], ss [7];
  logic [7:0]  hi [7] = '{8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3a, 8'h3b};
  wire  [9:0]  green_luma_capture_in   = s[0];
  wire  [9:0]  blue_diff_capture_in    = s[1];
  wire  [9:0]  red_diff_capture_in     = s[2];
  wire  [9:0]  luma_processor_stage_in = s[3];
  wire  [9:0]  mixed_sync_in           = s[4];
  wire  [9:0]  cb_diff_in              = s[5];
  wire  [9:0]  cr_diff_in              = s[6];
  logic [31:0] rnd = 32'h0000002f;
  logic [15:0] exp_q [$];
  logic        rd_pend = 1'b0;
  int          errors = 0;
  int          comparisons = 0;

  video_grab_regs video_grab_regs_inst (.*);
  host_port_model host_port_model_inst (.clock_in(clock_in),
    .host_addr_out(reg_addr_in), .host_wdata_out(reg_wdata_in),
    .host_wr_out(reg_wr_in), .host_rd_out(reg_rd_in),
    .host_seq_out(reg_seq_in));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic void xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
  endfunction

  task automatic check(input string nm, input logic [9:0] got,
                       input logic [9:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_port_model_inst.put(a, d);
  endtask

  task automatic wait2();
    repeat (2) @(posedge clock_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic sq = 1'b0);
    exp_q.push_back({a, e});
    host_port_model_inst.get(a, sq);
  endtask

  always @(posedge clock_in)
  begin
    logic [15:0] e;
    if (rd_pend && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check($sformatf("read %h", e[15:8]), {2'b00, reg_rdata_out},
            {2'b00, e[7:0]});
    end
    rd_pend = reg_rd_in;
  end

  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  initial
  begin
    repeat (20000) @(posedge clock_in);
    errors++;
    conclude();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [31:0] v;
    int i, b, p;
    sys_rst_in = 1'b1;
    {pal_mode_in, vblank_in, pixel_count_in, line_count_in} = '0;
    {field_count_in, oscillator_sine_in} = '0;
    line_in_field_in = 10'h064;
    frame_line_in = 10'h064;
    line_identifier_in = 5'h1f;
    s = '{default: '0};
    repeat (10) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd(8'h33, 8'h00);
    rd(8'h3f, 8'h00);
    xs();
    wr(8'h33, rnd[7:0]);
    rd(8'h33, {1'b0, rnd[6:0]});
    wr(8'h3d, 8'h5a);
    rd(8'h3d, 8'h00);
    rd(8'h50, 8'h00);
    // Second pass proves the snapshot refreshes after a hold
    pixel_count_in <= 11'h5a3;
    wr(8'h31, 8'ha3);
    wr(8'h33, 8'h05);
    for (i = 0; i < 7; i++)
    begin
      xs();
      s[i] <= rnd[9:0];
    end
    repeat (2)
    begin
      wr(8'h30, 8'h02);
      wr(8'h30, 8'h00);
      ss = s;
      for (i = 0; i < 7; i++)
      begin
        xs();
        s[i] <= rnd[9:0];
      end
      wr(8'h34, 8'hff);
      wr(8'h3c, 8'hff);
      for (i = 0; i < 7; i++)
        rd(hi[i], ss[i][9:2]);
      rd(8'h37, {2'b00, ss[0][1:0], ss[1][1:0], ss[2][1:0]});
      rd(8'h3c, {ss[3][1:0], ss[4][1:0], ss[5][1:0], ss[6][1:0]});
    end
    xs();
    oscillator_sine_in <= rnd[9:0];
    rd(8'h40, rnd[9:2]);
    wr(8'h3f, 8'h2c);
    rd(8'h3e, 8'h00);
    rd(8'h00, 8'h2c, 1'b1);
    rd(8'h00, 8'h2c, 1'b1);
    for (b = 0; b < 2; b++)
    begin
      wr(8'h3f, b ? 8'h80 : 8'h00);
      for (i = 15; i < 22; i++)
      begin
        line_in_field_in <= i[9:0];
        wait2();
        check("v flag", trs_v_flag_out, i <= (b ? 20 : 16));
      end
    end
    pal_mode_in <= 1'b1;
    line_in_field_in <= 10'h005;
    for (i = 0; i < 4; i++)
    begin
      vblank_in <= i[0];
      wait2();
      check("pal v flag", trs_v_flag_out, i[0]);
    end
    pal_mode_in <= 1'b0;
    wr(8'h3f, 8'h40);
    for (i = 4; i < 9; i++)
    begin
      line_identifier_in <= i[4:0];
      wait2();
      check("bypass", setup_strip_bypass_out, i <= 6);
    end
    line_identifier_in <= 5'h1f;
    for (p = 0; p < 2; p++)
      for (b = 0; b < 6; b++)
      begin
        pal_mode_in <= p[0];
        wr(8'h3f, 8'h01 << b);
        v = b > 2 ? (p ? 22 : 21) + 5 - b : (p ? 334 : 283) + 2 - b;
        frame_line_in <= v[9:0];
        wait2();
        check("flat", caption_flat_out, 10'h001);
        check("strip", setup_strip_bypass_out, 10'h001);
        frame_line_in <= v[9:0] + 10'h001;
        wait2();
        check("flat off", caption_flat_out, 10'h000);
      end
    pal_mode_in <= 1'b0;
    wr(8'h32, 8'h1c);
    wr(8'h33, 8'h38);
    pixel_count_in <= 11'h000;
    field_count_in <= 3'h3;
    line_count_in <= 9'h11b;
    wr(8'h30, 8'h20);
    line_count_in <= 9'h11c;
    v = 0;
    repeat (8)
    begin
      @(posedge clock_in);
      v = v + line_freeze_out;
    end
    check("freeze pulses", v[9:0], 10'h001);
    line_count_in <= 9'h11b;
    rd(8'h30, 8'h60);
    wr(8'h30, 8'h20);
    rd(8'h30, 8'h20);
    wr(8'h30, 8'h60);
    rd(8'h30, 8'h20);
    repeat (4) @(posedge clock_in);
    conclude();
  end
endmodule
